// [core/hic_top.sv]
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Keyed-hash opcode 0x11 with mode byte, two selector bytes, no data.
// - Low four selector bits pick the key slot; all sixteen go into message.
// - Selected slot key keys the HMAC; 32-byte digest is the answer.
// - Message: 32 zeros, scratch digest, opcode, mode, selector, 11 zeros, serial.
// - Serial tail 8, 4-7, 0-1, 2-3; mode bit 6 clear zeroes bytes 2-7.
// - Mode bit 2 unequal to source flag gives an execution error.
// - Information opcode 0x30, mode byte, two parameter bytes; four-byte answer.
// - Information answer is four bytes chosen by the mode value.
// - Undefined information mode gives a parse error.
// - Mode 0x00 returns revision word: product byte then silicon revision byte.
// - Mode 0x01 returns one when the named slot key is valid.
// - Mode 0x02 first byte: no-MAC, keygen, digestgen, source flags, scratch slot.
// - Second byte: valid, authorized slot, authorization valid, seed flags; rest zero.
module hic_top #(
  parameter logic [7:0] PRODUCT_ID  = hic_pkg::PRODUCT_ID_DEF,
  parameter logic [7:0] SILICON_REV = hic_pkg::SILICON_REV_DEF
) (
  input  wire logic         CLK_SYS,
  input  wire logic         RSTN,
  input  wire logic [10:0]  AVS_ADDRESS,
  input  wire logic         AVS_READ,
  input  wire logic         AVS_WRITE,
  input  wire logic [31:0]  AVS_WRITEDATA,
  input  wire logic [3:0]   AVS_BYTEENABLE,
  output wire logic [31:0]  AVS_READDATA,
  output wire logic         AVS_WAITREQUEST,
  output wire logic         IRQ,
  output wire logic         HASH_VALID,
  output wire logic [31:0]  HASH_DATA,
  output wire logic         HASH_KEY,
  output wire logic         HASH_LAST,
  input  wire logic         HASH_READY,
  input  wire logic         HASH_DONE,
  input  wire logic [255:0] HASH_DIGEST
);
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} hic_state_t;
  hic_state_t       state_q;
  hic_state_t       state_d;
  logic             wait_q;
  logic [31:0]      rdata_q;
  logic [31:0]      cmd_q;
  logic [15:0]      flags_q;
  logic [15:0]      kvalid_q;
  logic [2:0][31:0] serial_q;
  logic [7:0][31:0] scratch_q;
  logic [7:0][31:0] result_q;
  logic [7:0][31:0] digest_w;
  logic [7:0]       err_q;
  logic [1:0]       irq_sts_q;
  logic [1:0]       irq_sts_d;
  logic [1:0]       irq_mask_q;
  logic [1:0]       irq_mask_d;
  logic             irq_q;
  logic [4:0]       cnt_q;
  logic [4:0]       widx_q;
  logic             hv_q;
  logic [31:0]      hd_q;
  logic             hk_q;
  logic             hl_q;
  logic [31:0]      key_mem [128];
  default clocking cb_sys @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  hic_cmd_if c ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [10:0] addr, input logic [10:0] ofs,
                               input logic [10:0] mask);
    hit = ((addr ^ ofs) & mask) == 11'h000;
  endfunction : hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction : merge

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic       req     = AVS_READ | AVS_WRITE;
  wire logic       wr      = AVS_WRITE & ~wait_q;
  wire logic       busy    = state_q != ST_IDLE;
  wire logic       wr_open = wr & ~busy;
  wire logic [1:0] s_idx   = AVS_ADDRESS[3:2];
  wire logic [2:0] w_idx   = AVS_ADDRESS[4:2];
  wire logic [6:0] k_idx   = AVS_ADDRESS[8:2];
  wire logic [31:0] flags_m = merge({16'h0000, flags_q}, AVS_WRITEDATA, AVS_BYTEENABLE);

  wire logic h_ctrl  = hit(AVS_ADDRESS, hic_pkg::OFS_CTRL, hic_pkg::MASK_WORD);
  wire logic h_cmd   = hit(AVS_ADDRESS, hic_pkg::OFS_CMD, hic_pkg::MASK_WORD);
  wire logic h_stat  = hit(AVS_ADDRESS, hic_pkg::OFS_STATUS, hic_pkg::MASK_WORD);
  wire logic h_ists  = hit(AVS_ADDRESS, hic_pkg::OFS_IRQ_STS, hic_pkg::MASK_WORD);
  wire logic h_imask = hit(AVS_ADDRESS, hic_pkg::OFS_IRQ_MASK, hic_pkg::MASK_WORD);
  wire logic h_flags = hit(AVS_ADDRESS, hic_pkg::OFS_FLAGS, hic_pkg::MASK_WORD);
  wire logic h_kval  = hit(AVS_ADDRESS, hic_pkg::OFS_KEY_VALID, hic_pkg::MASK_WORD);
  wire logic h_ser   = hit(AVS_ADDRESS, hic_pkg::OFS_SERIAL, hic_pkg::MASK_4W) & (s_idx != 2'h3);
  wire logic h_scr   = hit(AVS_ADDRESS, hic_pkg::OFS_SCRATCH, hic_pkg::MASK_8W);
  wire logic h_res   = hit(AVS_ADDRESS, hic_pkg::OFS_RESULT, hic_pkg::MASK_8W);
  wire logic h_key   = hit(AVS_ADDRESS, hic_pkg::OFS_KEY_MEM, hic_pkg::MASK_KEY);

  wire logic [31:0] status_w = {16'h0000, err_q, 7'h00, busy};
  wire logic [31:0] rd_mux   = h_cmd   ? cmd_q :
                               h_stat  ? status_w :
                               h_ists  ? {30'h0000_0000, irq_sts_q} :
                               h_imask ? {30'h0000_0000, irq_mask_q} :
                               h_flags ? {16'h0000, flags_q} :
                               h_kval  ? {16'h0000, kvalid_q} :
                               h_ser   ? serial_q[s_idx] :
                               h_scr   ? scratch_q[w_idx] :
                               h_res   ? result_q[w_idx] : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= ~(req & wait_q);
      rdata_q <= (AVS_READ & wait_q) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cmd_q     <= hic_pkg::RST_CMD;
      flags_q   <= hic_pkg::RST_FLAGS;
      kvalid_q  <= hic_pkg::RST_KVALID;
      serial_q  <= '0;
      scratch_q <= '0;
    end else begin
      if (wr_open & h_cmd) cmd_q <= merge(cmd_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      if (wr_open & h_flags) flags_q <= flags_m[15:0];
      if (wr_open & h_kval) kvalid_q <= AVS_WRITEDATA[15:0];
      if (wr_open & h_ser) serial_q[s_idx] <= merge(serial_q[s_idx], AVS_WRITEDATA,
                                                    AVS_BYTEENABLE);
      if (wr_open & h_scr) scratch_q[w_idx] <= merge(scratch_q[w_idx], AVS_WRITEDATA,
                                                     AVS_BYTEENABLE);
    end
  end

  // Write-only key slots
  always_ff @(posedge CLK_SYS) begin
    if (wr_open & h_key) key_mem[k_idx] <= merge(key_mem[k_idx], AVS_WRITEDATA, AVS_BYTEENABLE);
  end

  // ----------------------------------------------------------------
  // Command fields to the builder and responder
  // ----------------------------------------------------------------
  wire logic [7:0]  op   = cmd_q[7:0];
  wire logic [7:0]  mode = cmd_q[15:8];
  wire logic [15:0] sel  = cmd_q[31:16];

  assign c.mode      = mode;
  assign c.selector  = sel;
  assign c.scratch   = scratch_q;
  assign c.serial    = serial_q;
  assign c.flags     = flags_q;
  assign c.key_valid = kvalid_q;
  assign c.word_idx  = cnt_q - hic_pkg::KEY_WORDS;

  hic_msg_builder u_msg (
    .c (c.msg)
  );

  hic_info_resp #(
    .PRODUCT_ID  (PRODUCT_ID),
    .SILICON_REV (SILICON_REV)
  ) u_info (
    .c (c.info)
  );

  // ----------------------------------------------------------------
  // Command checks
  // ----------------------------------------------------------------
  // Reserved mode bits
  wire logic       hm_rsvd = |(mode & hic_pkg::HMAC_MODE_RSVD);
  wire logic       src_bad = mode[hic_pkg::HMAC_SRC_BIT] != flags_q[hic_pkg::FLG_SRC_BIT];
  wire logic [7:0] st_err  = (op == hic_pkg::OP_HMAC) ?
                               (hm_rsvd ? hic_pkg::ERR_PARSE :
                                src_bad ? hic_pkg::ERR_EXEC : hic_pkg::ERR_NONE) :
                             (op == hic_pkg::OP_INFO) ?
                               (c.info_err ? hic_pkg::ERR_PARSE : hic_pkg::ERR_NONE) :
                             hic_pkg::ERR_PARSE;

  wire logic go      = wr & h_ctrl & AVS_BYTEENABLE[0] & AVS_WRITEDATA[hic_pkg::CTRL_GO_BIT];
  wire logic start   = go & ~busy;
  wire logic ok      = st_err == hic_pkg::ERR_NONE;
  wire logic hmac_ok = start & ok & (op == hic_pkg::OP_HMAC);
  wire logic info_ok = start & ok & (op == hic_pkg::OP_INFO);
  wire logic adv     = ~hv_q | HASH_READY;
  wire logic fin     = (state_q == ST_WAIT) & HASH_DONE;
  wire logic done_ev = info_ok | fin;
  wire logic err_ev  = start & ~ok;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (hmac_ok) state_d = ST_SEND;
      ST_SEND: if (adv && cnt_q == hic_pkg::STREAM_WORDS) state_d = ST_WAIT;
      ST_WAIT: if (HASH_DONE) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      err_q   <= hic_pkg::ERR_NONE;
    end else begin
      state_q <= state_d;
      if (start) err_q <= st_err;
    end
  end

  // ----------------------------------------------------------------
  // Key then message stream
  // ----------------------------------------------------------------
  // Key words from the low-nibble slot
  wire logic [31:0] next_word = (cnt_q < hic_pkg::KEY_WORDS) ? key_mem[{sel[3:0], cnt_q[2:0]}] :
                                c.msg_word;
  wire logic        more      = cnt_q != hic_pkg::STREAM_WORDS;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cnt_q  <= 5'h00;
      widx_q <= 5'h00;
      hv_q   <= 1'b0;
      hd_q   <= 32'h0000_0000;
      hk_q   <= 1'b0;
      hl_q   <= 1'b0;
    end else if (hmac_ok) begin
      cnt_q <= 5'h00;
    end else if (state_q == ST_SEND && adv) begin
      hv_q   <= more;
      hd_q   <= next_word;
      hk_q   <= cnt_q < hic_pkg::KEY_WORDS;
      hl_q   <= cnt_q == hic_pkg::STREAM_WORDS - 5'h01;
      widx_q <= cnt_q;
      if (more) cnt_q <= cnt_q + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Answer words
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dig
      assign digest_w[gi] = HASH_DIGEST[255 - 32*gi -: 32];
    end
  endgenerate

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      result_q <= '0;
    end else if (fin) begin
      result_q <= digest_w;
    end else if (info_ok) begin
      result_q <= {224'h0, c.info_word};
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire logic [1:0] w1c = (wr & h_ists & AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[1:0] : 2'h0;
  assign irq_sts_d  = (irq_sts_q & ~w1c) | {err_ev, done_ev};
  assign irq_mask_d = (wr & h_imask & AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[1:0] : irq_mask_q;
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      irq_sts_q  <= 2'h0;
      irq_mask_q <= hic_pkg::RST_IRQ_MASK;
      irq_q      <= 1'b0;
    end else begin
      irq_sts_q  <= irq_sts_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= |(irq_sts_d & irq_mask_d);
    end
  end

  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign IRQ             = irq_q;
  assign HASH_VALID      = hv_q;
  assign HASH_DATA       = hd_q;
  assign HASH_KEY        = hk_q;
  assign HASH_LAST       = hl_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_bus_answer;
    req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("Bus answer timing wrong");
  property p_header_word;
    HASH_VALID && widx_q == 5'h18 |-> HASH_DATA == {8'h11, mode, sel[7:0], sel[15:8]} && !HASH_KEY;
  endproperty
  a_header_word: assert property (p_header_word) else $error("Header word wrong");
  property p_key_word;
    HASH_VALID && HASH_KEY |-> HASH_DATA == key_mem[{sel[3:0], widx_q[2:0]}];
  endproperty
  a_key_word: assert property (p_key_word) else $error("Key word from wrong slot");
  property p_zero_head;
    HASH_VALID && widx_q >= 5'h08 && widx_q < 5'h10 |-> HASH_DATA == 32'h0000_0000;
  endproperty
  a_zero_head: assert property (p_zero_head) else $error("Message head not zero");
  property p_sn_gate;
    HASH_VALID && widx_q == 5'h1C && !mode[6] |-> HASH_DATA == 32'h0000_0000;
  endproperty
  a_sn_gate: assert property (p_sn_gate) else $error("Serial bytes not zeroed");
  property p_src_reject;
    start && op == 8'h11 && !hm_rsvd && src_bad |=> err_q == 8'h0F && !busy && irq_sts_q[1];
  endproperty
  a_src_reject: assert property (p_src_reject) else $error("Source mismatch accepted");
  property p_rsvd_reject;
    start && op == 8'h11 && hm_rsvd |=> err_q == 8'h03 && !busy;
  endproperty
  a_rsvd_reject: assert property (p_rsvd_reject) else $error("Reserved bits accepted");
  property p_bad_mode;
    start && op == 8'h30 && mode > 8'h02 |=> err_q == 8'h03;
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("Undefined mode accepted");
  property p_revision;
    start && op == 8'h30 && mode == 8'h00 |=>
      result_q[0] == {SILICON_REV, PRODUCT_ID, 16'h0000} && err_q == 8'h00;
  endproperty
  a_revision: assert property (p_revision) else $error("Revision word wrong");
  property p_key_valid;
    start && op == 8'h30 && mode == 8'h01 |=> result_q[0] == {31'h0, kvalid_q[sel[3:0]]};
  endproperty
  a_key_valid: assert property (p_key_valid) else $error("Validity answer wrong");
  property p_state_word;
    start && op == 8'h30 && mode == 8'h02 |=> result_q[0] == {16'h0000, flags_q};
  endproperty
  a_state_word: assert property (p_state_word) else $error("State word wrong");
  property p_stream_len;
    HASH_VALID && HASH_LAST |-> widx_q == 5'h1D;
  endproperty
  a_stream_len: assert property (p_stream_len) else $error("Stream length wrong");
endmodule : hic_top

`default_nettype wire

// [core/hic_pkg.sv]
`default_nettype none

package hic_pkg;
  // ----------------------------------------------------------------
  // Opcodes, modes and error codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_HMAC        = 8'h11;
  localparam logic [7:0] OP_INFO        = 8'h30;
  localparam logic [7:0] INFO_REVISION  = 8'h00;
  localparam logic [7:0] INFO_KEY_VALID = 8'h01;
  localparam logic [7:0] INFO_STATE     = 8'h02;
  localparam logic [7:0] HMAC_MODE_RSVD = 8'hBB;
  localparam int         HMAC_SN_BIT    = 6;
  localparam int         HMAC_SRC_BIT   = 2;
  localparam logic [7:0] ERR_NONE       = 8'h00;
  localparam logic [7:0] ERR_PARSE      = 8'h03;
  localparam logic [7:0] ERR_EXEC       = 8'h0F;
  // Arbitrary identity values
  localparam logic [7:0] PRODUCT_ID_DEF  = 8'hA5;
  localparam logic [7:0] SILICON_REV_DEF = 8'h01;

  // ----------------------------------------------------------------
  // Stream counts
  // ----------------------------------------------------------------
  localparam logic [4:0] KEY_WORDS    = 5'h08;
  localparam logic [4:0] STREAM_WORDS = 5'h1E;
  localparam logic [4:0] MSG_HDR_WORD = 5'h10;
  localparam logic [4:0] MSG_SN8_WORD = 5'h13;
  localparam logic [4:0] MSG_SN4_WORD = 5'h14;
  localparam logic [4:0] MSG_SN0_WORD = 5'h15;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [10:0] OFS_CTRL      = 11'h000;
  localparam logic [10:0] OFS_CMD       = 11'h004;
  localparam logic [10:0] OFS_STATUS    = 11'h008;
  localparam logic [10:0] OFS_IRQ_STS   = 11'h00C;
  localparam logic [10:0] OFS_IRQ_MASK  = 11'h010;
  localparam logic [10:0] OFS_FLAGS     = 11'h014;
  localparam logic [10:0] OFS_KEY_VALID = 11'h018;
  localparam logic [10:0] OFS_SERIAL    = 11'h020;
  localparam logic [10:0] OFS_SCRATCH   = 11'h040;
  localparam logic [10:0] OFS_RESULT    = 11'h060;
  localparam logic [10:0] OFS_KEY_MEM   = 11'h400;
  localparam logic [10:0] MASK_WORD     = 11'h7FC;
  localparam logic [10:0] MASK_4W       = 11'h7F0;
  localparam logic [10:0] MASK_8W       = 11'h7E0;
  localparam logic [10:0] MASK_KEY      = 11'h600;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_GO_BIT    = 0;
  localparam int STS_BUSY_BIT   = 0;
  localparam int STS_ERR_LSB    = 8;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_ERR_BIT    = 1;
  localparam int FLG_SRC_BIT    = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_CMD      = 32'h0000_0000;
  localparam logic [15:0] RST_FLAGS    = 16'h0000;
  localparam logic [15:0] RST_KVALID   = 16'h0000;
  localparam logic [1:0]  RST_IRQ_MASK = 2'h0;
endpackage : hic_pkg

`default_nettype wire

// [core/hic_cmd_if.sv]
`timescale 1ns/100ps
`default_nettype none

interface hic_cmd_if;
  logic [7:0]       mode;
  logic [15:0]      selector;
  logic [7:0][31:0] scratch;
  logic [2:0][31:0] serial;
  logic [15:0]      flags;
  logic [15:0]      key_valid;
  logic [4:0]       word_idx;
  logic [31:0]      msg_word;
  logic [31:0]      info_word;
  logic             info_err;

  modport ctl  (output mode, selector, scratch, serial, flags, key_valid, word_idx,
                input  msg_word, info_word, info_err);
  modport msg  (input mode, selector, scratch, serial, word_idx, output msg_word);
  modport info (input mode, selector, flags, key_valid, output info_word, info_err);
endinterface : hic_cmd_if

`default_nettype wire

// [core/hic_msg_builder.sv]
`timescale 1ns/100ps
`default_nettype none

module hic_msg_builder (
  hic_cmd_if.msg c
);
  wire logic [71:0] snb  = {c.serial[2][7:0], c.serial[1], c.serial[0]};
  wire logic        incl = c.mode[hic_pkg::HMAC_SN_BIT];

  function automatic logic [7:0] sn(input int k);
    sn = snb[8*k +: 8];
  endfunction : sn

  // ----------------------------------------------------------------
  // Message word select
  // ----------------------------------------------------------------
  // Zero head, scratch digest, header
  wire logic [31:0] scr_w = c.scratch[c.word_idx[2:0]];
  wire logic [31:0] hdr_w = {hic_pkg::OP_HMAC, c.mode, c.selector[7:0], c.selector[15:8]};
  wire logic [31:0] sn8_w = {24'h000000, sn(8)};
  wire logic [31:0] sn4_w = incl ? {sn(4), sn(5), sn(6), sn(7)} : 32'h0000_0000;
  wire logic [31:0] sn0_w = {sn(0), sn(1), incl ? {sn(2), sn(3)} : 16'h0000};

  assign c.msg_word = (c.word_idx[4:3] == 2'h1)               ? scr_w :
                      (c.word_idx == hic_pkg::MSG_HDR_WORD) ? hdr_w :
                      (c.word_idx == hic_pkg::MSG_SN8_WORD) ? sn8_w :
                      (c.word_idx == hic_pkg::MSG_SN4_WORD) ? sn4_w :
                      (c.word_idx == hic_pkg::MSG_SN0_WORD) ? sn0_w : 32'h0000_0000;
endmodule : hic_msg_builder

`default_nettype wire

// [core/hic_info_resp.sv]
`timescale 1ns/100ps
`default_nettype none

module hic_info_resp #(
  parameter logic [7:0] PRODUCT_ID  = hic_pkg::PRODUCT_ID_DEF,
  parameter logic [7:0] SILICON_REV = hic_pkg::SILICON_REV_DEF
) (
  hic_cmd_if.info c
);
  wire logic kv = c.key_valid[c.selector[3:0]];

  // ----------------------------------------------------------------
  // Answer word, first byte in low bits
  // ----------------------------------------------------------------
  // Mode dependent answer
  assign c.info_word = (c.mode == hic_pkg::INFO_REVISION)  ? {SILICON_REV, PRODUCT_ID, 16'h0000} :
                       (c.mode == hic_pkg::INFO_KEY_VALID) ? {31'h0000_0000, kv} :
                       (c.mode == hic_pkg::INFO_STATE)     ? {16'h0000, c.flags} : 32'h0000_0000;
  assign c.info_err  = c.mode > hic_pkg::INFO_STATE;
endmodule : hic_info_resp

`default_nettype wire

// [test/hic_eng_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Hash engine stand-in
// ------------------------------
module hic_eng_model (
  input  wire logic         CLK_SYS,
  input  wire logic         RSTN,
  input  wire logic         SLOW,
  input  wire logic         HASH_VALID,
  input  wire logic [31:0]  HASH_DATA,
  input  wire logic         HASH_KEY,
  input  wire logic         HASH_LAST,
  output var  logic         HASH_READY,
  output var  logic         HASH_DONE,
  output wire logic [255:0] HASH_DIGEST
);
  logic [31:0] words [0:31];
  logic [31:0] keys;
  logic [4:0]  cnt;
  logic [4:0]  lst;
  logic [2:0]  dly;
  assign HASH_DIGEST = {8{32'h9E37_79B9}} ^ {255'h0, 1'b1} ^ {256{~HASH_DONE}};
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cnt <= 5'h00;
      lst <= 5'h00;
      dly <= 3'h0;
      keys <= 32'h0;
      HASH_READY <= 1'b0;
      HASH_DONE <= 1'b0;
    end else begin
      HASH_READY <= SLOW ? ~HASH_READY : 1'b1;
      HASH_DONE <= (dly == 3'h1);
      if (dly != 3'h0) dly <= dly - 3'h1;
      if (HASH_VALID && HASH_READY) begin
        words[cnt] <= HASH_DATA;
        keys[cnt] <= HASH_KEY;
        cnt <= HASH_LAST ? 5'h00 : cnt + 5'h01;
        if (HASH_LAST) lst <= cnt;
        if (HASH_LAST) dly <= 3'h4;
      end
    end
  end
endmodule : hic_eng_model
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Register-level bench
// ------------------------------
module tb_top;
  logic CLK_SYS = 1'b0, RSTN = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0, SLOW = 1'b0;
  logic [10:0] AVS_ADDRESS = 11'h000;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, HASH_DATA, q, st;
  logic AVS_WAITREQUEST, IRQ, HASH_VALID, HASH_KEY, HASH_LAST, HASH_READY, HASH_DONE;
  logic [255:0] HASH_DIGEST;
  int err_total = 0;
  int compares = 0;
  always #5 CLK_SYS = ~CLK_SYS;
  hic_top dut (.CLK_SYS, .RSTN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA, .AVS_WAITREQUEST, .IRQ, .HASH_VALID, .HASH_DATA,
    .HASH_KEY, .HASH_LAST, .HASH_READY, .HASH_DONE, .HASH_DIGEST);
  hic_eng_model eng (.CLK_SYS, .RSTN, .SLOW, .HASH_VALID, .HASH_DATA, .HASH_KEY,
    .HASH_LAST, .HASH_READY, .HASH_DONE, .HASH_DIGEST);
  task automatic conclude();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [10:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= ~w;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    r = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    chk("bus answer", 32'(n < 20), 32'h1);
    if (n >= 20) conclude();
    @(posedge CLK_SYS);
  endtask : acc
  task automatic run(input logic [31:0] c, input logic [7:0] e);
    int n;
    n = 0;
    acc(1'b1, 11'h004, c, q);
    acc(1'b1, 11'h000, 32'h1, q);
    do begin
      acc(1'b0, 11'h008, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 300);
    chk("busy clear", 32'(n < 300), 32'h1);
    if (n >= 300) conclude();
    chk("status", {16'h0, st[15:0]}, {16'h0, e, 8'h00});
    acc(1'b0, 11'h00C, 32'h0, q);
    chk("irq status", q, (e == 8'h00) ? 32'h1 : 32'h2);
    chk("irq set", {31'h0, IRQ}, 32'h1);
    acc(1'b1, 11'h00C, 32'h3, q);
    @(posedge CLK_SYS);
    chk("irq clear", {31'h0, IRQ}, 32'h0);
    acc(1'b0, 11'h060, 32'h0, q);
  endtask : run
  initial begin
    repeat (5) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    @(posedge CLK_SYS);
    acc(1'b1, 11'h010, 32'h3, q);
    acc(1'b0, 11'h1F0, 32'h0, q);
    chk("unmapped", q, 32'h0);
    acc(1'b1, 11'h014, 32'hA5C3, q);
    acc(1'b1, 11'h018, 32'h20, q);
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 11'h040 + 11'(4 * i), 32'h5C00_0000 + 32'(i), q);
      acc(1'b1, 11'h460 + 11'(4 * i), 32'hC0DE_0000 + 32'(i), q);
      if (i < 3) acc(1'b1, 11'h020 + 11'(4 * i), 32'h1312_1110 + 32'h0404_0404 * 32'(i), q);
    end
    run(32'h0000_0030, 8'h00);
    chk("revision", q, {hic_pkg::SILICON_REV_DEF, hic_pkg::PRODUCT_ID_DEF, 16'h0});
    run(32'h0005_0130, 8'h00);
    chk("slot 5 valid", q, 32'h1);
    run(32'h0004_0130, 8'h00);
    chk("slot 4 valid", q, 32'h0);
    run(32'h0000_0230, 8'h00);
    chk("state", q, 32'hA5C3);
    run(32'h0000_0330, 8'h03);
    run(32'h0000_FF30, 8'h03);
    run(32'hAB93_0411, 8'h0F);
    run(32'hAB93_8011, 8'h03);
    for (int m = 0; m < 2; m++) begin
      SLOW <= m[0];
      run(m ? 32'hAB93_0011 : 32'hAB93_4011, 8'h00);
      for (int k = 0; k < 8; k++) begin
        acc(1'b0, 11'h060 + 11'(4 * k), 32'h0, q);
        chk("digest", q, 32'h9E37_79B9 ^ 32'(k / 7));
        chk("key", eng.words[k], 32'hC0DE_0000 + 32'(k));
        chk("zeros", eng.words[8 + k], 32'h0);
        chk("scratch", eng.words[16 + k], 32'h5C00_0000 + 32'(k));
      end
      chk("fields", eng.words[24], m ? 32'h1100_93AB : 32'h1140_93AB);
      chk("pad", eng.words[25] | eng.words[26], 32'h0);
      chk("sn8", eng.words[27], 32'h18);
      chk("sn4", eng.words[28], m ? 32'h0 : 32'h1415_1617);
      chk("sn0", eng.words[29], m ? 32'h1011_0000 : 32'h1011_1213);
      chk("key flags", eng.keys, 32'hFF);
      chk("length", {27'h0, eng.lst}, 32'h1D);
    end
    conclude();
  end
endmodule : tb_top
`default_nettype wire
